// [hw/mrf_pkg.sv]
// Shared constants, state encodings and CRC step for the serial slave framer.
package mrf_pkg;

  // System clock rate and the supported line rates.
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_1200 = 1200;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;

  // Clock cycles per bit, rounded down; the two slow ones default top parameters.
  localparam int BIT_CYC_1200_DEF = CLK_HZ / BAUD_1200;
  localparam int BIT_CYC_2400_DEF = CLK_HZ / BAUD_2400;
  localparam int BIT_CYC_9600 = CLK_HZ / BAUD_9600;
  localparam int BIT_CYC_19200 = CLK_HZ / BAUD_19200;
  localparam int CNT_W = 14;

  // Character shape and the silent gap, kept in tenths of a character.
  localparam int DATA_BITS = 8;
  localparam int CHAR_BITS = 10;
  localparam int GAP_TENTHS = 35;
  localparam int GAP_BITS = (GAP_TENTHS * CHAR_BITS) / 10;
  localparam logic [5:0] GAP_LAST = 6'(GAP_BITS - 1);

  // Switch positions: switch n sits on bit n-1, high means on.
  localparam int SW_BAUD_LSB = 0;
  localparam int SW_BAUD_MSB = 1;
  localparam int SW_ADDR_LSB = 2;
  localparam int SW_ADDR_MSB = 6;
  localparam int SW_TEST = 7;

  // Baud selection codes, switch 2 the high bit and switch 1 the low bit.
  localparam logic [1:0] BAUD_SEL_1200 = 2'h0;
  localparam logic [1:0] BAUD_SEL_2400 = 2'h1;
  localparam logic [1:0] BAUD_SEL_9600 = 2'h2;
  localparam logic [1:0] BAUD_SEL_19200 = 2'h3;

  // Message constants.
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] FUNC_EXC_MASK = 8'h80;
  localparam logic [7:0] MIN_FRAME = 8'h04;
  localparam logic [7:0] FC_RD_SET = 8'h03;
  localparam logic [7:0] FC_RD_ACT = 8'h04;
  localparam logic [7:0] FC_EXEC = 8'h05;
  localparam logic [7:0] FC_ST_ONE = 8'h06;
  localparam logic [7:0] FC_STATUS = 8'h07;
  localparam logic [7:0] FC_ST_MULT = 8'h10;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REV = 16'ha001;

  // Transmit FIFO shape: eight data bits plus a last-byte marker.
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 8;

  typedef enum logic [3:0] {
    R_IDLE = 4'b0001,
    R_START = 4'b0010,
    R_DATA = 4'b0100,
    R_STOP = 4'b1000
  } mrf_rx_st_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_LOAD = 3'b010,
    T_SEND = 3'b100
  } mrf_tx_st_t;

  typedef enum logic [4:0] {
    S_ADDR = 5'b00001,
    S_FUNC = 5'b00010,
    S_BODY = 5'b00100,
    S_CRCH = 5'b01000,
    S_CRCL = 5'b10000
  } mrf_tx_sel_t;

  // One byte of the reflected CRC-16: fold the byte into the low half, then shift eight times.
  function automatic logic [15:0] mrf_crc_upd(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] a;
    a = crc ^ {8'h00, d};
    for (int j = 0; j < DATA_BITS; j++) begin
      a = a[0] ? ({1'b0, a[15:1]} ^ CRC_POLY_REV) : {1'b0, a[15:1]};
    end
    return a;
  endfunction

endpackage

// [hw/mrf_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module mrf_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } mrf_fifo_st_t;

  mrf_fifo_st_t s;
  mrf_fifo_st_t next_s;
  logic full;
  logic empty;

  // Pointers carry one extra wrap bit so full and empty stay distinct.
  assign empty = (s.wp == s.rp);
  assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = s.mem[s.rp[AW-1:0]];

  // Push and pop may both happen in one cycle.
  always_comb begin
    next_s = s;
    if (in_valid_in && !full) begin
      next_s.mem[s.wp[AW-1:0]] = in_data_in;
      next_s.wp = s.wp + 1'b1;
    end
    if (out_ready_in && !empty) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  // The storage is cleared too, so a stale word never reads as unknown.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// [hw/mrf_framer.sv]
// Serial slave framer: character timing, address match, CRC check and response send.
// Function
// - Ten-bit character: start, eight data, stop.
// - Only 1200, 2400, 9600, 19200 baud.
// - Switch 2 on, switch 1 off selects 9600.
// - Station address is weighted sum of switches 3-7.
// - Switch 8 enables communications test mode.
// - Device answers only, never starts a transfer.
// - Binary message form only, no text form.
// - Half duplex; line released when not answering.
// - Address, function, data, two check bytes.
// - Answer only requests carrying own address.
// - Response opens with own station address.
// - Address zero: act, but never answer.
// - Performed function echoes function byte unchanged.
// - Refused function returns byte with top bit set.
// - Gap over 3.5 characters restarts reception.
// - CRC covers data bits of bytes only.
// - Check value last, high byte first.
// - Bad check: discard, no action, no answer.
// - CRC register preset to all ones.
// - Shift right, low bit carries out, zero in.
// - XOR byte low, eight steps, XOR polynomial.
// - Function codes 03-07 and 16 are supported.
`timescale 1ns/1ns
`default_nettype none
module mrf_framer #(
  parameter int BIT_CYC_1200 = mrf_pkg::BIT_CYC_1200_DEF,
  parameter int BIT_CYC_2400 = mrf_pkg::BIT_CYC_2400_DEF
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] switch_in,
  input wire logic rx_line_in,
  output logic tx_line_out,
  output logic tx_oe_out,
  output logic [1:0] baud_sel_out,
  output logic [7:0] station_addr_out,
  output logic test_mode_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic req_ok_out,
  output logic req_bad_out,
  output logic req_bcast_out,
  output logic [7:0] req_func_out,
  output logic req_func_known_out,
  input wire logic rsp_go_in,
  input wire logic rsp_exc_in,
  output logic rsp_pending_out,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic tx_busy_out
);
  import mrf_pkg::*;

  typedef struct packed {
    logic [7:0] sw_s1;
    logic [7:0] sw_s2;
    logic rx_s1;
    logic rx_s2;
    logic [CNT_W-1:0] tick_cnt;
    logic [5:0] gap_cnt;
    mrf_rx_st_t rx_st;
    logic [CNT_W-1:0] rx_cnt;
    logic [3:0] rx_nbit;
    logic [7:0] rx_sh;
    logic f_active;
    logic f_skip;
    logic f_ferr;
    logic f_bcast;
    logic [7:0] f_idx;
    logic [7:0] f_b1;
    logic [7:0] f_b2;
    logic [7:0] f_func;
    logic [15:0] f_crc;
    logic pend;
    logic [7:0] rsp_func;
    logic [7:0] rx_data;
    logic rx_valid;
    logic req_ok;
    logic req_bad;
    logic req_bcast;
    logic [7:0] req_func;
    logic req_known;
    mrf_tx_st_t tx_st;
    mrf_tx_sel_t tx_sel;
    logic tx_exc;
    logic tx_final;
    logic [9:0] tx_sh;
    logic [CNT_W-1:0] tx_cnt;
    logic [3:0] tx_nbit;
    logic [15:0] tx_crc;
    logic tx_line;
    logic tx_oe;
  } mrf_state_t;

  mrf_state_t s;
  mrf_state_t next_s;
  logic [CNT_W-1:0] bit_cyc;
  logic [CNT_W-1:0] bit_last;
  logic [CNT_W-1:0] half_last;
  logic [7:0] station;
  logic fifo_valid;
  logic fifo_rd;
  logic [FIFO_W-1:0] fifo_data;

  // Decodes the function codes this relay serves; anything else shows as unknown on req_func_known_out.
  function automatic logic func_known(input logic [7:0] fc);
    case (fc)
      FC_RD_SET, FC_RD_ACT, FC_EXEC, FC_ST_ONE, FC_STATUS, FC_ST_MULT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Bit period from switches 1 and 2; only the four listed rates exist.
  always_comb begin
    case (s.sw_s2[SW_BAUD_MSB:SW_BAUD_LSB])
      BAUD_SEL_1200: bit_cyc = CNT_W'(BIT_CYC_1200);
      BAUD_SEL_2400: bit_cyc = CNT_W'(BIT_CYC_2400);
      BAUD_SEL_9600: bit_cyc = CNT_W'(BIT_CYC_9600);
      default: bit_cyc = CNT_W'(BIT_CYC_19200);
    endcase
  end

  // Switch weights 1, 2, 4, 8, 16 for switches 3 to 7 make a plain binary address.
  assign station = 8'(s.sw_s2[SW_ADDR_MSB:SW_ADDR_LSB]);
  assign bit_last = bit_cyc - 1'b1;
  assign half_last = (bit_cyc >> 1) - 1'b1;

  // Response body bytes wait here; a slow line drains it, so the user sees back-pressure.
  mrf_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .in_data_in({tx_last_in, tx_data_in}),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_rd),
    .out_data_out(fifo_data)
  );

  // Next state for the receiver, frame checker and transmitter.
  always_comb begin
    logic tick;
    logic byte_ev;
    logic frame_end;
    logic ok;
    logic load;
    logic [7:0] rb;
    logic [7:0] tb;
    mrf_tx_sel_t nsel;
    tick = 1'b0;
    byte_ev = 1'b0;
    frame_end = 1'b0;
    ok = 1'b0;
    load = 1'b0;
    rb = s.rx_sh;
    tb = 8'h00;
    nsel = s.tx_sel;
    fifo_rd = 1'b0;
    next_s = s;
    next_s.rx_valid = 1'b0;
    next_s.req_ok = 1'b0;
    next_s.req_bad = 1'b0;

    // Pins and switches come from outside; two flops before any use.
    next_s.sw_s1 = switch_in;
    next_s.sw_s2 = s.sw_s1;
    next_s.rx_s1 = rx_line_in;
    next_s.rx_s2 = s.rx_s1;

    // Free-running bit tick paces the silence timer; >= survives a rate change.
    tick = (s.tick_cnt >= bit_last);
    next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;

    // Receiver: the line is ignored while we drive it, so our own echo never lands.
    case (s.rx_st)
      R_IDLE: begin
        if (!s.rx_s2 && !s.tx_oe) begin
          next_s.rx_st = R_START;
          next_s.rx_cnt = '0;
        end
      end
      R_START: begin
        if (s.rx_cnt >= half_last) begin
          next_s.rx_cnt = '0;
          next_s.rx_nbit = '0;
          next_s.rx_st = s.rx_s2 ? R_IDLE : R_DATA;
        end else begin
          next_s.rx_cnt = s.rx_cnt + 1'b1;
        end
      end
      R_DATA: begin
        if (s.rx_cnt >= bit_last) begin
          next_s.rx_cnt = '0;
          next_s.rx_sh = {s.rx_s2, s.rx_sh[7:1]};
          next_s.rx_nbit = s.rx_nbit + 1'b1;
          if (s.rx_nbit == 4'(DATA_BITS - 1)) begin
            next_s.rx_st = R_STOP;
          end
        end else begin
          next_s.rx_cnt = s.rx_cnt + 1'b1;
        end
      end
      R_STOP: begin
        if (s.rx_cnt >= bit_last) begin
          next_s.rx_st = R_IDLE;
          byte_ev = 1'b1;
        end else begin
          next_s.rx_cnt = s.rx_cnt + 1'b1;
        end
      end
      default: next_s.rx_st = R_IDLE;
    endcase

    // Silence timer counts whole bit times; a running character holds it at zero.
    if (s.rx_st != R_IDLE) begin
      next_s.gap_cnt = '0;
    end else if (tick && s.f_active) begin
      next_s.gap_cnt = s.gap_cnt + 1'b1;
    end
    frame_end = s.f_active && (s.rx_st == R_IDLE) && tick && (s.gap_cnt == GAP_LAST);

    // Each character is a raw byte; no text framing is looked for.
    if (byte_ev) begin
      next_s.f_active = 1'b1;
      if (!s.rx_s2) begin
        next_s.f_ferr = 1'b1;
      end
      if (s.f_idx == 8'h00) begin
        next_s.f_skip = !((rb == station) || (rb == ADDR_BCAST));
        next_s.f_bcast = (rb == ADDR_BCAST);
        next_s.pend = 1'b0;
      end
      // Bytes enter the CRC two behind, so the check bytes never do.
      if (s.f_idx >= 8'h02) begin
        next_s.f_crc = mrf_crc_upd(s.f_crc, s.f_b1);
      end
      if ((s.f_idx >= 8'h03) && !s.f_skip) begin
        next_s.rx_data = s.f_b1;
        next_s.rx_valid = 1'b1;
      end
      if (s.f_idx == 8'h03) begin
        next_s.f_func = s.f_b1;
      end
      next_s.f_b1 = s.f_b2;
      next_s.f_b2 = rb;
      next_s.f_idx = (s.f_idx == 8'hff) ? s.f_idx : s.f_idx + 1'b1;
    end

    // End of message: check value must match, high byte first, else drop it silently.
    if (frame_end) begin
      ok = !s.f_skip && !s.f_ferr && (s.f_idx >= MIN_FRAME)
        && ({s.f_b1, s.f_b2} == s.f_crc);
      if (!s.f_skip) begin
        next_s.req_ok = ok;
        next_s.req_bad = !ok;
        next_s.req_func = s.f_func;
        next_s.req_bcast = s.f_bcast;
        next_s.req_known = func_known(s.f_func);
      end
      if (ok && !s.f_bcast) begin
        next_s.pend = 1'b1;
        next_s.rsp_func = s.f_func;
      end
      next_s.f_active = 1'b0;
      next_s.f_skip = 1'b0;
      next_s.f_ferr = 1'b0;
      next_s.f_bcast = 1'b0;
      next_s.f_idx = '0;
      next_s.f_crc = CRC_INIT;
    end

    // Transmitter: only a pending request may open a response, and never on a start bit.
    case (s.tx_st)
      T_IDLE: begin
        if (rsp_go_in && s.pend && (s.rx_st == R_IDLE) && s.rx_s2) begin
          next_s.tx_st = T_LOAD;
          next_s.tx_sel = S_ADDR;
          next_s.tx_crc = CRC_INIT;
          next_s.tx_exc = rsp_exc_in;
          next_s.tx_final = 1'b0;
          next_s.pend = 1'b0;
        end
      end
      T_LOAD: begin
        load = 1'b1;
        case (s.tx_sel)
          S_ADDR: begin
            tb = station;
            nsel = S_FUNC;
          end
          S_FUNC: begin
            tb = s.tx_exc ? (s.rsp_func | FUNC_EXC_MASK) : s.rsp_func;
            nsel = S_BODY;
          end
          S_BODY: begin
            load = fifo_valid;
            fifo_rd = fifo_valid;
            tb = fifo_data[DATA_BITS-1:0];
            nsel = fifo_data[DATA_BITS] ? S_CRCH : S_BODY;
          end
          S_CRCH: begin
            tb = s.tx_crc[15:8];
            nsel = S_CRCL;
          end
          default: begin
            tb = s.tx_crc[7:0];
            nsel = S_CRCL;
            next_s.tx_final = 1'b1;
          end
        endcase
        if (load) begin
          next_s.tx_sh = {1'b1, tb, 1'b0};
          next_s.tx_cnt = '0;
          next_s.tx_nbit = '0;
          next_s.tx_st = T_SEND;
          next_s.tx_sel = nsel;
          if ((s.tx_sel != S_CRCH) && (s.tx_sel != S_CRCL)) begin
            next_s.tx_crc = mrf_crc_upd(s.tx_crc, tb);
          end
        end
      end
      T_SEND: begin
        if (s.tx_cnt >= bit_last) begin
          next_s.tx_cnt = '0;
          next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
          next_s.tx_nbit = s.tx_nbit + 1'b1;
          if (s.tx_nbit == 4'(CHAR_BITS - 1)) begin
            next_s.tx_st = s.tx_final ? T_IDLE : T_LOAD;
          end
        end else begin
          next_s.tx_cnt = s.tx_cnt + 1'b1;
        end
      end
      default: next_s.tx_st = T_IDLE;
    endcase

    // Line idles high and the driver is off outside a response.
    next_s.tx_line = (next_s.tx_st == T_SEND) ? next_s.tx_sh[0] : 1'b1;
    next_s.tx_oe = (next_s.tx_st != T_IDLE);
  end

  // Reset loads constants only; the line synchronisers start at the idle line level, the switch ones at zero.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
      s.rx_st <= R_IDLE;
      s.tx_st <= T_IDLE;
      s.tx_sel <= S_ADDR;
      s.tx_line <= 1'b1;
      s.f_crc <= CRC_INIT;
      s.tx_crc <= CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops.
  assign tx_line_out = s.tx_line;
  assign tx_oe_out = s.tx_oe;
  assign tx_busy_out = s.tx_oe;
  assign baud_sel_out = s.sw_s2[SW_BAUD_MSB:SW_BAUD_LSB];
  assign station_addr_out = station;
  assign test_mode_out = s.sw_s2[SW_TEST];
  assign rx_data_out = s.rx_data;
  assign rx_valid_out = s.rx_valid;
  assign req_ok_out = s.req_ok;
  assign req_bad_out = s.req_bad;
  assign req_bcast_out = s.req_bcast;
  assign req_func_out = s.req_func;
  assign req_func_known_out = s.req_known;
  assign rsp_pending_out = s.pend;

  // Checks on the protocol behaviour, all in the one clock domain.
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  a_resp_needs_req:
    assert property ($rose(s.tx_oe) |-> $past(s.pend) && $past(rsp_go_in))
    else $error("driver enabled without a pending request");

  a_half_duplex:
    assert property (s.tx_oe |-> (s.rx_st == R_IDLE) && (s.tx_st != T_IDLE))
    else $error("receiving while driving the line");

  a_bcast_silent:
    assert property (req_ok_out && req_bcast_out |-> !s.pend ##1 !s.tx_oe)
    else $error("broadcast left a response pending");

  a_bad_crc_drop:
    assert property (req_bad_out |-> !s.pend && !$rose(s.tx_oe))
    else $error("bad message left a response pending");

  a_first_byte_addr:
    assert property (s.tx_st == T_LOAD && s.tx_sel == S_ADDR |=> s.tx_sh[8:1] == station)
    else $error("response does not open with the station address");

  a_func_echo:
    assert property (s.tx_st == T_LOAD && s.tx_sel == S_FUNC && !s.tx_exc
      |=> s.tx_sh[8:1] == $past(s.rsp_func))
    else $error("function byte not echoed");

  a_func_exc:
    assert property (s.tx_st == T_LOAD && s.tx_sel == S_FUNC && s.tx_exc
      |=> s.tx_sh[8] && s.tx_sh[7:1] == $past(s.rsp_func[6:0]))
    else $error("exception byte lacks its top bit");

  a_crc_high_first:
    assert property (s.tx_st == T_LOAD && s.tx_sel == S_CRCH
      |=> s.tx_sh[8:1] == $past(s.tx_crc[15:8]))
    else $error("check value high byte not sent first");

  a_gap_restart:
    assert property (s.f_active && s.rx_st == R_IDLE && s.gap_cnt == GAP_LAST
      && s.tick_cnt >= bit_last |=> s.f_idx == 8'h00 && !s.f_active)
    else $error("long gap did not restart reception");

  a_crc_preset:
    assert property ($rose(s.tx_oe) |-> s.tx_crc == CRC_INIT)
    else $error("transmit check register not preset");

  a_frame_bits:
    assert property (s.tx_st == T_SEND && s.tx_nbit == 4'(CHAR_BITS - 1) |-> tx_line_out)
    else $error("stop bit not high");

  a_baud_9600:
    assert property (s.sw_s2[SW_BAUD_MSB:SW_BAUD_LSB] == BAUD_SEL_9600
      |-> bit_cyc == CNT_W'(BIT_CYC_9600))
    else $error("9600 baud not selected");
endmodule
`default_nettype wire

// [verif/mrf_master.sv]
// Behavioural bus master: sends request characters and decodes the answer.
`timescale 1ns/1ns
`default_nettype none
module mrf_master (
  input wire logic sys_clk_in,
  input wire logic line_in,
  input wire logic [15:0] bit_cyc_in,
  output logic drive_out,
  output logic got_valid_out,
  output logic [7:0] got_byte_out
);
  logic [7:0] sh;

  // One ten-bit character; the line is left high, its biased idle level.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drive_out <= fr[i];
      repeat (bit_cyc_in) @(posedge sys_clk_in);
    end
  endtask

  // Decode answers at mid-bit; a bad stop bit drops the byte, so it shows as missing.
  initial begin
    drive_out = 1'b1;
    got_valid_out = 1'b0;
    got_byte_out = 8'h00;
    forever begin
      @(posedge sys_clk_in);
      got_valid_out <= 1'b0;
      if (line_in === 1'b0 && drive_out === 1'b1) begin
        repeat (bit_cyc_in / 2) @(posedge sys_clk_in);
        for (int i = 0; i < 8; i++) begin
          repeat (bit_cyc_in) @(posedge sys_clk_in);
          sh[i] = line_in;
        end
        repeat (bit_cyc_in) @(posedge sys_clk_in);
        got_byte_out <= sh;
        got_valid_out <= line_in;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/mrf_framer_tb_top.sv]
// Self-checking bench for the serial slave framer with a behavioural master.
`timescale 1ns/1ns
`default_nettype none
module mrf_framer_tb_top;
  import mrf_pkg::*;
  localparam int C1200 = 20;
  localparam int C2400 = 16;
  logic sys_clk_in, nrst_in, rx_line, tx_line, tx_oe, drive, got_valid;
  logic [7:0] switch_in, rx_data, func, station, tx_data, got_byte, sw;
  logic [1:0] baud_sel;
  logic test_mode, rx_valid, req_ok, req_bad, req_bcast, known;
  logic rsp_go, rsp_exc, pending, tx_last, tx_valid, tx_ready, tx_busy;
  logic [15:0] bit_cyc;
  logic [11:0] expq[$];
  logic [7:0] fcs[$];
  int fails, checks_done, seed;

  mrf_framer #(.BIT_CYC_1200(C1200), .BIT_CYC_2400(C2400)) u_mrf_framer (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .switch_in(switch_in),
    .rx_line_in(rx_line), .tx_line_out(tx_line), .tx_oe_out(tx_oe),
    .baud_sel_out(baud_sel), .station_addr_out(station), .test_mode_out(test_mode),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .req_ok_out(req_ok),
    .req_bad_out(req_bad), .req_bcast_out(req_bcast), .req_func_out(func),
    .req_func_known_out(known), .rsp_go_in(rsp_go), .rsp_exc_in(rsp_exc),
    .rsp_pending_out(pending), .tx_data_in(tx_data), .tx_last_in(tx_last),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_busy_out(tx_busy));

  mrf_master u_mrf_master (.sys_clk_in(sys_clk_in), .line_in(rx_line),
    .bit_cyc_in(bit_cyc), .drive_out(drive), .got_valid_out(got_valid),
    .got_byte_out(got_byte));

  // One shared wire: the slave owns it only while its driver is enabled.
  assign rx_line = (tx_oe === 1'b1) ? tx_line : drive;

  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] expv);
    checks_done++;
    if (seen !== expv) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // An event with no note waiting is unexpected and compares against unknown.
  task automatic note(input logic [11:0] seen);
    if (expq.size() == 0) check(seen, 12'hxxx);
    else check(seen, expq.pop_front());
  endtask

  // Watcher: each observed result takes the oldest note off the queue.
  always @(posedge sys_clk_in) begin
    if (rx_valid === 1'b1) note({4'h1, rx_data});
    if (req_ok === 1'b1) note({4'h2, func});
    if (req_bad === 1'b1) note(12'h300);
    if (got_valid === 1'b1) note({4'h4, got_byte});
    if (tx_oe === 1'b1 && drive === 1'b0) note(12'hfff);
  end

  task automatic wait_empty(input int lim);
    for (int n = 0; expq.size() != 0; n++) begin
      @(posedge sys_clk_in);
      if (n > lim) begin
        fails++;
        $display("CHECK FAILED at %0t: result missing", $time);
        end_sim();
      end
    end
  endtask

  // Reflected CRC, preset to all ones, eight shifts per byte.
  function automatic logic [15:0] crc_of(input logic [7:0] m[$]);
    logic [15:0] a;
    a = 16'hffff;
    foreach (m[i]) begin
      a[7:0] = a[7:0] ^ m[i];
      repeat (8) a = a[0] ? ((a >> 1) ^ 16'ha001) : (a >> 1);
    end
    return a;
  endfunction

  // Request from the master; a nonzero flip spoils the low check byte.
  task automatic run_req(input logic [7:0] m[$], input logic [7:0] flip, input logic exc);
    logic [7:0] r[$];
    logic [15:0] c;
    logic us, bc;
    us = (m[0] == 8'h0a) || (m[0] == 8'h00);
    bc = (m[0] == 8'h00);
    if (us) begin
      for (int i = 1; i < m.size(); i++) expq.push_back({4'h1, m[i]});
      expq.push_back((flip == 8'h00) ? {4'h2, m[1]} : 12'h300);
    end
    c = crc_of(m) ^ {8'h00, flip};
    m.push_back(c[15:8]);
    m.push_back(c[7:0]);
    foreach (m[i]) u_mrf_master.send_byte(m[i]);
    repeat (38 * int'(bit_cyc)) @(posedge sys_clk_in);
    wait_empty(8 * int'(bit_cyc));
    if (!us || flip != 8'h00 || bc) begin
      check(12'({pending, req_bcast}), 12'({1'b0, bc && flip == 8'h00}));
    end else begin
      check(12'({pending, known}), 12'({1'b1, m[1] inside {[8'h03:8'h07], 8'h10}}));
      r = '{8'h0a, exc ? (m[1] | 8'h80) : m[1]};
      // Fill the transmit FIFO to its depth, then offer one more that must be refused.
      for (int i = 0; i < 8; i++) begin
        r.push_back(8'($random(seed)));
        @(posedge sys_clk_in);
        tx_data <= r[i + 2];
        tx_last <= (i == 7);
        tx_valid <= 1'b1;
      end
      @(posedge sys_clk_in);
      tx_data <= 8'hee;
      tx_last <= 1'b0;
      @(posedge sys_clk_in);
      check(12'(tx_ready), 12'h000);
      tx_valid <= 1'b0;
      c = crc_of(r);
      r.push_back(c[15:8]);
      r.push_back(c[7:0]);
      foreach (r[i]) expq.push_back({4'h4, r[i]});
      rsp_exc <= exc;
      rsp_go <= 1'b1;
      @(posedge sys_clk_in);
      rsp_go <= 1'b0;
      wait_empty(160 * int'(bit_cyc));
      // The last byte is decoded mid stop bit; the driver lets go only after it ends.
      repeat (int'(bit_cyc)) @(posedge sys_clk_in);
      check(12'({tx_oe, pending}), 12'h000);
    end
  endtask

  initial begin
    seed = 32'hbaeebf71;
    fails = 0;
    checks_done = 0;
    nrst_in = 1'b0;
    switch_in = 8'h00;
    rsp_go = 1'b0;
    rsp_exc = 1'b0;
    tx_data = 8'h00;
    tx_last = 1'b0;
    tx_valid = 1'b0;
    bit_cyc = 16'(C1200);
    fcs = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10, 8'h41};
    repeat (6) @(posedge sys_clk_in);
    check(12'({tx_oe, tx_line}), 12'h001);
    nrst_in <= 1'b1;
    // Switch decoding, starting with 9600 baud at station 10.
    for (int k = 0; k < 9; k++) begin
      sw = (k == 0) ? 8'h2a : 8'($random(seed));
      @(posedge sys_clk_in);
      switch_in <= sw;
      repeat (4) @(posedge sys_clk_in);
      check(12'(baud_sel), 12'(sw[1:0]));
      check(12'(station), 12'(sw[6:2]));
      check(12'(test_mode), 12'(sw[7]));
    end
    // The slow rate runs one request; the faster one walks every function code.
    for (int b = 0; b < 2; b++) begin
      bit_cyc = 16'((b == 0) ? C1200 : C2400);
      switch_in <= {1'b0, 5'h0a, 2'(b)};
      repeat (4) @(posedge sys_clk_in);
      foreach (fcs[i]) begin
        if (b == 1 || i == 0) run_req('{8'h0a, fcs[i], 8'h00, 8'(i)}, 8'h00, fcs[i] == 8'h41);
      end
    end
    run_req('{8'h0a, 8'h04, 8'h00, 8'h08}, 8'h01, 1'b0);
    run_req('{8'h0b, 8'h06, 8'h00, 8'h02}, 8'h00, 1'b0);
    run_req('{8'h00, 8'h05, 8'h01, 8'hff}, 8'h00, 1'b0);
    // A request cut short by silence is dropped; the next one is heard.
    expq.push_back(12'h300);
    u_mrf_master.send_byte(8'h0a);
    u_mrf_master.send_byte(8'h03);
    wait_empty(45 * int'(bit_cyc));
    run_req('{8'h0a, 8'h03, 8'h00, 8'h40}, 8'h00, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
